// [hw/lube_fault_supervisor.sv]
`timescale 1ns/100ps
// Contract
// - on any fault, stop normal sequence, latch fault, present it
// - classify fault as warning or malfunction by severity
// - pulses still missing after retries: close valve and raise fault
// - fault-state timer counts time from fault raised to acknowledge
// - on acknowledge, fault-state time is added into fault hours
// - fault hours sum all fault intervals over unit life
// - fault hours are nonvolatile and cannot be cleared
// - fault hours displayed as two groups of three digits
// - fault hours display saturates at 99 999.9 hours
// - fault hours count in 0.1 hour steps only
// - no pulse in run time: leave normal, enter block pause
// - no pulse in block pause: start another block lubrication cycle
// - pulse during block operation: resume normal, starting with pause
// - three runs and two block pauses without pulse: no-progress fault
// - block pause 6, 12 or 15 minutes from pause setting
// - indicator flashes on pump fault, steady on external input fault
// - disable affected zone or all zones depending on fault type
// - acknowledge key or optional pressure switch clears and restarts
module lube_fault_supervisor #(
  parameter int unsigned SEC_DIV = lube_pkg::SEC_CYCLES
) (
  input  wire logic                  clk_i,
  input  wire logic                  resetn_i,
  input  wire logic                  detector_i,        // piston detector pin
  input  wire logic                  ack_key_i,         // acknowledge key pin
  input  wire logic                  external_pressure_switch_i,
  input  wire logic                  pressure_switch_en_i,
  input  wire logic                  ext_input_fault_i, // signal input fault, level
  input  wire logic                  pump_run_i,        // sequencer in pump run time
  input  wire logic                  run_end_i,         // pulse at run time end
  input  wire logic [7:0]            pause_time_setting_i,
  input  wire logic [1:0]            zone_i,            // zone being lubricated
  input  wire logic                  fault_hours_param_i,
  input  wire logic                  fh_nv_valid_i,     // nonvolatile image ready
  input  wire logic [19:0]           fh_nv_i,           // restored fault hours
  output logic                       halt_o,
  output logic                       block_mode_o,
  output logic                       start_run_o,
  output logic [3:0]                 zone_enable_o,
  output lube_pkg::fault_info_s      fault_o,
  output logic                       led_red_o,
  output logic                       fh_store_o,
  output logic [19:0]                fault_hours_o,
  output logic [11:0]                display_o,
  output logic                       display_group_o,
  output logic [19:0]                fault_state_o
);
  import lube_pkg::*;

  localparam int unsigned SEC_W = $clog2(SEC_CYCLES + 1);

  logic              det_lvl;
  logic              ack_lvl;
  logic              psw_lvl;
  logic              ext_lvl;
  logic              det_prev;
  logic              ack_prev;
  logic              psw_prev;
  logic              det_pulse;
  logic              ack_pulse;
  logic [SEC_W-1:0]  sec_cnt;
  logic              sec_tick;
  logic [9:0]        pause_cnt;
  logic [9:0]        block_pause_s;
  logic [8:0]        tenth_cnt;
  logic [1:0]        runs_done;
  logic              seen_pulse;
  logic              flash;
  logic [1:0]        fault_zone;
  logic              fault_all;
  logic [20:0]       fh_sum;
  logic              fh_loaded;
  logic [9:0]        hi_digits;
  logic [9:0]        lo_digits;
  seq_state_e        state;
  seq_state_e        next_state;

  // pins cross into the clock domain through three stages
  pin_sync u_det (.clk_i(clk_i), .resetn_i(resetn_i), .pin_i(detector_i), .level_o(det_lvl));
  pin_sync u_ack (.clk_i(clk_i), .resetn_i(resetn_i), .pin_i(ack_key_i), .level_o(ack_lvl));
  pin_sync u_psw (.clk_i(clk_i), .resetn_i(resetn_i),
                  .pin_i(external_pressure_switch_i), .level_o(psw_lvl));
  pin_sync u_ext (.clk_i(clk_i), .resetn_i(resetn_i),
                  .pin_i(ext_input_fault_i), .level_o(ext_lvl));

  // rising edges of the cleaned levels
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      det_prev <= 1'b0;
      ack_prev <= 1'b0;
      psw_prev <= 1'b0;
    end else begin
      det_prev <= det_lvl;
      ack_prev <= ack_lvl;
      psw_prev <= psw_lvl;
    end
  end

  assign det_pulse = det_lvl & ~det_prev;
  assign ack_pulse = (ack_lvl & ~ack_prev)
                   | (pressure_switch_en_i & psw_lvl & ~psw_prev);

  // one-second prescaler drives every timer
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      sec_cnt <= '0;
    end else if (sec_cnt == SEC_W'(SEC_DIV - 1)) begin
      sec_cnt <= '0;
    end else begin
      sec_cnt <= sec_cnt + 1'b1;
    end
  end
  assign sec_tick = (sec_cnt == SEC_W'(SEC_DIV - 1));

  // block pause length from the normal pause setting
  always_comb begin
    if (pause_time_setting_i <= PAUSE_0P1) begin
      block_pause_s = 10'(BLOCK_PAUSE1_S);
    end else if (pause_time_setting_i == PAUSE_0P2) begin
      block_pause_s = 10'(BLOCK_PAUSE2_S);
    end else begin
      block_pause_s = 10'(BLOCK_PAUSE3_S);
    end
  end

  // sequence state machine, block retries and fault halt
  always_comb begin
    next_state = state;
    case (state)
      ST_NORMAL_PAUSE: begin
        if (pump_run_i) begin
          next_state = ST_NORMAL_RUN;
        end
      end
      ST_NORMAL_RUN: begin
        if (run_end_i && !seen_pulse && !det_pulse) begin
          next_state = ST_BLOCK_PAUSE;
        end else if (run_end_i) begin
          next_state = ST_NORMAL_PAUSE;
        end
      end
      ST_BLOCK_PAUSE: begin
        if (det_pulse) begin
          next_state = ST_NORMAL_PAUSE;
        end else if (sec_tick && pause_cnt >= block_pause_s - 10'h001) begin
          next_state = ST_BLOCK_RUN;
        end
      end
      ST_BLOCK_RUN: begin
        if (det_pulse) begin
          next_state = ST_NORMAL_PAUSE;
        end else if (run_end_i && runs_done == BLOCK_RUNS - 2'h1) begin
          next_state = ST_FAULT;
        end else if (run_end_i) begin
          next_state = ST_BLOCK_PAUSE;
        end
      end
      ST_FAULT: begin
        if (ack_pulse) begin
          next_state = ST_NORMAL_PAUSE;
        end
      end
      default: next_state = ST_NORMAL_PAUSE;
    endcase
    if (ext_lvl && state != ST_FAULT) begin
      next_state = ST_FAULT;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      state <= ST_NORMAL_PAUSE;
    end else begin
      state <= next_state;
    end
  end

  // counts runs in the block sequence, the first missed normal run is one
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      runs_done <= 2'h0;
    end else if (state == ST_NORMAL_RUN && next_state == ST_BLOCK_PAUSE) begin
      runs_done <= 2'h1;
    end else if (state == ST_BLOCK_RUN && next_state == ST_BLOCK_PAUSE) begin
      runs_done <= runs_done + 2'h1;
    end else if (next_state == ST_NORMAL_PAUSE) begin
      runs_done <= 2'h0;
    end
  end

  // a pulse anywhere in the run time counts
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      seen_pulse <= 1'b0;
    end else if (state != ST_NORMAL_RUN) begin
      seen_pulse <= 1'b0;
    end else if (det_pulse) begin
      seen_pulse <= 1'b1;
    end
  end

  // block pause timer in seconds
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      pause_cnt <= '0;
    end else if (state != ST_BLOCK_PAUSE) begin
      pause_cnt <= '0;
    end else if (sec_tick) begin
      pause_cnt <= pause_cnt + 10'h001;
    end
  end

  // latched fault and classification; held until acknowledge
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      fault_o    <= '0;
      fault_zone <= 2'h0;
      fault_all  <= 1'b0;
    end else if (state != ST_FAULT && next_state == ST_FAULT) begin
      fault_zone <= zone_i;
      if (ext_lvl) begin
        fault_o   <= '{warning: 1'b1, malfunction: 1'b0, code: FC_EXT_INPUT};
        fault_all <= 1'b1;
      end else begin
        fault_o   <= '{warning: 1'b0, malfunction: 1'b1, code: FC_NO_PROGRESS};
        fault_all <= 1'b0;
      end
    end else if (state == ST_FAULT && ack_pulse) begin
      fault_o   <= '0;
      fault_all <= 1'b0;
    end
  end

  // zone gating: affected valve or every zone shut while faulted
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      zone_enable_o <= 4'hF;
    end else if (next_state == ST_FAULT) begin
      for (int z = 0; z < 4; z++) begin
        if (state != ST_FAULT) begin
          zone_enable_o[z] <= !(ext_lvl || zone_i == 2'(z));
        end else begin
          zone_enable_o[z] <= !(fault_all || fault_zone == 2'(z));
        end
      end
    end else begin
      zone_enable_o <= 4'hF;
    end
  end

  // sequencer handshakes
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      halt_o       <= 1'b0;
      block_mode_o <= 1'b0;
      start_run_o  <= 1'b0;
    end else begin
      halt_o       <= (next_state == ST_FAULT);
      block_mode_o <= (next_state == ST_BLOCK_PAUSE) || (next_state == ST_BLOCK_RUN);
      start_run_o  <= (state == ST_BLOCK_PAUSE) && (next_state == ST_BLOCK_RUN);
    end
  end

  // indicator: toggles each second on pump fault, steady for input fault
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      flash     <= 1'b0;
      led_red_o <= 1'b0;
    end else begin
      if (sec_tick) begin
        flash <= ~flash;
      end
      if (state != ST_FAULT) begin
        led_red_o <= 1'b0;
      end else if (fault_o.code == FC_EXT_INPUT) begin
        led_red_o <= 1'b1;
      end else begin
        led_red_o <= flash;
      end
    end
  end

  // fault-state timer in tenths of an hour; partial steps are dropped
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      tenth_cnt     <= '0;
      fault_state_o <= '0;
    end else if (state != ST_FAULT) begin
      tenth_cnt     <= '0;
      fault_state_o <= '0;
    end else if (sec_tick) begin
      if (tenth_cnt == 9'(TENTH_HOUR_S - 1)) begin
        tenth_cnt     <= '0;
        fault_state_o <= fault_state_o + 20'h00001;
      end else begin
        tenth_cnt <= tenth_cnt + 9'h001;
      end
    end
  end
  assign fh_sum = {1'b0, fault_hours_o} + {1'b0, fault_state_o};

  // accumulator restored from nonvolatile image, never cleared by reset
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      fh_loaded  <= 1'b0;
      fh_store_o <= 1'b0;
    end else begin
      fh_store_o <= 1'b0;
      if (!fh_loaded && fh_nv_valid_i) begin
        fh_loaded <= 1'b1;
      end else if (fh_loaded && state == ST_FAULT && ack_pulse) begin
        fh_store_o <= 1'b1;
      end
    end
  end

  // fault_hours has no reset branch: the nonvolatile image loads it, acknowledge adds to it
  always_ff @(posedge clk_i) begin
    if (!fh_loaded && fh_nv_valid_i) begin
      fault_hours_o <= (fh_nv_i > FH_MAX) ? FH_MAX : fh_nv_i;
    end else if (fh_loaded && resetn_i && state == ST_FAULT && ack_pulse) begin
      fault_hours_o <= (fh_sum > {1'b0, FH_MAX}) ? FH_MAX : fh_sum[19:0];
    end
  end

  // display: upper and lower three decimal digits, BCD packed
  assign hi_digits = 10'(fault_hours_o / 20'h003E8);
  assign lo_digits = 10'(fault_hours_o % 20'h003E8);

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      display_group_o <= 1'b0;
      display_o       <= '0;
    end else if (fault_hours_param_i) begin
      if (sec_tick) begin
        display_group_o <= ~display_group_o;
      end
      if (sec_tick == display_group_o) begin // digits follow the group this edge sets
        display_o <= {4'(hi_digits / 10'd100), 4'((hi_digits / 10'd10) % 10'd10),
                      4'(hi_digits % 10'd10)};
      end else begin
        display_o <= {4'(lo_digits / 10'd100), 4'((lo_digits / 10'd10) % 10'd10),
                      4'(lo_digits % 10'd10)};
      end
    end else begin
      display_group_o <= 1'b0;
      display_o       <= '0;
    end
  end

  a_block_to_fault: assert property (@(posedge clk_i) disable iff (!resetn_i)
    state == ST_BLOCK_RUN && run_end_i && !det_pulse && !ext_lvl && runs_done == 2'h2
    |=> state == ST_FAULT ##1 halt_o) else $error("no fault after third run");
  a_pulse_resumes: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (state == ST_BLOCK_PAUSE || state == ST_BLOCK_RUN) && det_pulse && !ext_lvl
    |=> state == ST_NORMAL_PAUSE) else $error("block not aborted by pulse");
  a_run_miss: assert property (@(posedge clk_i) disable iff (!resetn_i)
    state == ST_NORMAL_RUN && run_end_i && !seen_pulse && !det_pulse && !ext_lvl
    |=> state == ST_BLOCK_PAUSE) else $error("missed run not blocked");
  a_ack_clears: assert property (@(posedge clk_i) disable iff (!resetn_i)
    state == ST_FAULT && ack_pulse |=> fault_o == '0 && state == ST_NORMAL_PAUSE)
    else $error("acknowledge did not clear");
  a_fh_ceiling: assert property (@(posedge clk_i) disable iff (!resetn_i)
    fh_loaded |-> fault_hours_o <= FH_MAX) else $error("fault hours above limit");
  a_fh_monotone: assert property (@(posedge clk_i) disable iff (!resetn_i)
    fh_loaded && $past(fh_loaded) |-> fault_hours_o >= $past(fault_hours_o))
    else $error("fault hours decreased");
  a_fh_add: assert property (@(posedge clk_i) disable iff (!resetn_i)
    fh_loaded && state == ST_FAULT && ack_pulse && fh_sum <= {1'b0, FH_MAX}
    |=> fault_hours_o == $past(fh_sum[19:0])) else $error("fault time not added");
  a_halt_fault: assert property (@(posedge clk_i) disable iff (!resetn_i)
    state == ST_FAULT |-> halt_o && zone_enable_o != 4'hF)
    else $error("fault without halt");
  a_ext_steady: assert property (@(posedge clk_i) disable iff (!resetn_i)
    state == ST_FAULT && fault_o.code == FC_EXT_INPUT |=> led_red_o)
    else $error("input fault not steady");
  a_block_pause_len: assert property (@(posedge clk_i) disable iff (!resetn_i)
    state == ST_BLOCK_PAUSE |-> pause_cnt < block_pause_s)
    else $error("block pause overran");
endmodule : lube_fault_supervisor

// [hw/lube_pkg.sv]
package lube_pkg;

  // timing: 20 MHz system clock, prescaled to a one-second tick
  localparam int unsigned CLK_HZ         = 20_000_000;
  localparam int unsigned SEC_CYCLES     = CLK_HZ;          // cycles per second
  localparam int unsigned TENTH_HOUR_S   = 360;             // 0.1 h = 6 min
  localparam int unsigned BLOCK_PAUSE1_S = 360;             // 6 min
  localparam int unsigned BLOCK_PAUSE2_S = 720;             // 12 min
  localparam int unsigned BLOCK_PAUSE3_S = 900;             // 15 min

  // retry sequence: three run times, two block pauses
  localparam logic [1:0] BLOCK_RUNS      = 2'h3;

  // fault hours in tenths, display ceiling 99 999.9 h
  localparam logic [19:0] FH_MAX         = 20'hF423F;       // 999 999 tenths
  localparam logic [19:0] FH_RESET       = 20'h00000;

  // pause setting in tenths of an hour
  localparam logic [7:0] PAUSE_0P1       = 8'h01;
  localparam logic [7:0] PAUSE_0P2       = 8'h02;

  // fault codes
  localparam logic [3:0] FC_NONE         = 4'h0;
  localparam logic [3:0] FC_NO_PROGRESS  = 4'h1;            // no_progress_fault_code
  localparam logic [3:0] FC_EXT_INPUT    = 4'h2;

  typedef enum logic [2:0] {
    ST_NORMAL_PAUSE = 3'b000,
    ST_NORMAL_RUN   = 3'b001,
    ST_BLOCK_PAUSE  = 3'b010,
    ST_BLOCK_RUN    = 3'b011,
    ST_FAULT        = 3'b100
  } seq_state_e;

  // fault classification and fault code travel together
  typedef struct packed {
    logic       warning;
    logic       malfunction;
    logic [3:0] code;
  } fault_info_s;

endpackage : lube_pkg

// [hw/pin_sync.sv]
`timescale 1ns/100ps
// three-stage sampler: a change counts once stages two and three agree
module pin_sync (
  input  wire logic clk_i,
  input  wire logic resetn_i,
  input  wire logic pin_i,
  output logic      level_o
);
  logic s1;
  logic s2;
  logic s3;

  // s1 feeds only s2, avoids reading a metastable stage
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= pin_i;
      s2 <= s1;
      s3 <= s2;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      level_o <= 1'b0;
    end else if (s2 == s3) begin
      level_o <= s3;
    end
  end
endmodule : pin_sync

// [verification/lube_fault_supervisor_tb.sv]
`timescale 1ns/100ps
module lube_fault_supervisor_tb;
  import lube_pkg::*;
  localparam int unsigned SD = 4; // cycles per second in sim

  logic        clk_i = 1'b0;
  logic        resetn = 1'b0;
  logic        det_req = 1'b0;
  logic        key_req = 1'b0;
  logic        ext_sw = 1'b0;
  logic        sw_en = 1'b0;
  logic        ext_fault = 1'b0;
  logic        pump_run = 1'b0;
  logic        run_end = 1'b0;
  logic [7:0]  pause_set = 8'h01;
  logic [1:0]  zone = 2'h1;
  logic        fh_param = 1'b0;
  logic        nv_valid = 1'b0;
  logic [19:0] nv = 20'h00000;
  logic        detector, ack_key, halt, block_mode, start_run, led, fh_store, group;
  logic [3:0]  zone_en;
  fault_info_s fault;
  logic [19:0] fault_hours, fault_state;
  logic [11:0] disp;
  int          n_errors = 0;
  int          n_compared = 0;

  // clock: 50 ns period
  always #25 clk_i = ~clk_i;

  lube_field_model lube_field_model_inst (
    .clk_i(clk_i), .det_req_i(det_req), .key_req_i(key_req),
    .detector_o(detector), .ack_key_o(ack_key));

  lube_fault_supervisor #(.SEC_DIV(SD)) lube_fault_supervisor_inst (
    .clk_i(clk_i), .resetn_i(resetn), .detector_i(detector), .ack_key_i(ack_key),
    .external_pressure_switch_i(ext_sw), .pressure_switch_en_i(sw_en),
    .ext_input_fault_i(ext_fault), .pump_run_i(pump_run), .run_end_i(run_end),
    .pause_time_setting_i(pause_set), .zone_i(zone), .fault_hours_param_i(fh_param),
    .fh_nv_valid_i(nv_valid), .fh_nv_i(nv), .halt_o(halt), .block_mode_o(block_mode),
    .start_run_o(start_run), .zone_enable_o(zone_en), .fault_o(fault),
    .led_red_o(led), .fh_store_o(fh_store), .fault_hours_o(fault_hours),
    .display_o(disp), .display_group_o(group), .fault_state_o(fault_state));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // bounded wait on one design output, polled at the falling edge
  task automatic wait_on(input int sel, input int lim, output int n);
    n = 0;
    while (n < lim && !(sel == 0 ? block_mode === 1'b1 : sel == 1 ? start_run === 1'b1 :
           sel == 2 ? halt === 1'b1 : sel == 3 ? fh_store === 1'b1 : group === 1'b1)) begin
      @(negedge clk_i);
      n++;
    end
  endtask : wait_on

  // one pump run time, with or without a detector pulse inside it
  task automatic run_pump(input bit pulse);
    @(negedge clk_i);
    pump_run = 1'b1;
    det_req = pulse;
    @(negedge clk_i);
    det_req = 1'b0;
    repeat (12) @(negedge clk_i);
    run_end = 1'b1;
    @(negedge clk_i);
    run_end = 1'b0;
    pump_run = 1'b0;
  endtask : run_pump

  task automatic do_reset();
    @(negedge clk_i);
    resetn = 1'b0;
    repeat (12) @(negedge clk_i);
    resetn = 1'b1;
    @(negedge clk_i);
  endtask : do_reset

  // restored hours near the ceiling so the later fault saturates
  task automatic t_boot();
    do_reset();
    check("zone_enable", zone_en, 4'hF);
    check("halt", halt, 1'b0);
    nv = FH_MAX - 20'h1;
    nv_valid = 1'b1;
    @(negedge clk_i);
    nv_valid = 1'b0;
    repeat (2) @(negedge clk_i);
    check("fault_hours", fault_hours, FH_MAX - 20'h1);
    $display("test boot done");
  endtask : t_boot

  // upper group shown first after enable; lower checked first here, then upper
  task automatic t_display();
    int n;
    fh_param = 1'b1;
    wait_on(4, 20, n);
    check("display_lower", disp, 12'h998);
    while (n < 40 && group !== 1'b0) begin
      @(negedge clk_i);
      n++;
    end
    check("display_upper", disp, 12'h999);
    fh_param = 1'b0;
    $display("test display done");
  endtask : t_display

  task automatic t_good();
    run_pump(1'b1);
    repeat (10) @(negedge clk_i);
    check("block_mode", block_mode, 1'b0);
    $display("test good run done");
  endtask : t_good

  // missed run, timed block pause, then recovery on a pulse
  task automatic t_pause(input logic [7:0] set, input int secs);
    int n;
    pause_set = set;
    run_pump(1'b0);
    wait_on(0, 10, n);
    check("block_mode", block_mode, 1'b1);
    wait_on(1, 5000, n);
    check("pause_len", (n + 8 >= secs * SD) && (n <= secs * SD + 8), 1'b1);
    // pulse inside the block run; the sequencer then restarts with a pause
    det_req = 1'b1;
    @(negedge clk_i);
    det_req = 1'b0;
    repeat (10) @(negedge clk_i);
    check("block_mode", block_mode, 1'b0);
    check("halt", halt, 1'b0);
    $display("test pause %0d done", secs);
  endtask : t_pause

  task automatic t_no_progress();
    int n;
    logic l0;
    pause_set = PAUSE_0P1;
    run_pump(1'b0);
    wait_on(1, 2000, n);
    check("start_run", start_run, 1'b1);
    run_pump(1'b0);
    wait_on(1, 2000, n);
    check("start_run", start_run, 1'b1);
    run_pump(1'b0);
    wait_on(2, 10, n);
    check("halt", halt, 1'b1);
    check("fault", fault, {1'b0, 1'b1, FC_NO_PROGRESS});
    check("zone_enable", zone_en, 4'hD);
    l0 = led;
    n = 0;
    while (n < 12 && led === l0) begin
      @(negedge clk_i);
      n++;
    end
    check("led_flash", n < 12, 1'b1);
    // a little over two tenths of an hour
    repeat (2 * TENTH_HOUR_S * SD + 300) @(negedge clk_i);
    check("fault_state", fault_state, 20'h00002);
    key_req = 1'b1;
    @(negedge clk_i);
    key_req = 1'b0;
    wait_on(3, 20, n);
    check("fh_store", fh_store, 1'b1);
    check("fault_hours", fault_hours, FH_MAX);
    repeat (3) @(negedge clk_i);
    check("halt", halt, 1'b0);
    check("zone_enable", zone_en, 4'hF);
    $display("test no progress done");
  endtask : t_no_progress

  // external input fault, cleared through the pressure switch
  task automatic t_ext();
    int n;
    int chg;
    ext_fault = 1'b1;
    wait_on(2, 10, n);
    check("fault", fault, {1'b1, 1'b0, FC_EXT_INPUT});
    check("zone_enable", zone_en, 4'h0);
    chg = 0;
    repeat (12) begin
      @(negedge clk_i);
      chg += (led !== 1'b1);
    end
    check("led_steady", chg, 0);
    ext_fault = 1'b0;
    sw_en = 1'b1;
    ext_sw = 1'b1;
    repeat (6) @(negedge clk_i);
    ext_sw = 1'b0;
    repeat (10) @(negedge clk_i);
    check("halt", halt, 1'b0);
    check("fault", fault, 6'h00);
    check("fault_hours", fault_hours, FH_MAX);
    $display("test external done");
  endtask : t_ext

  // second reset: hours survive it, restore brings back the stored image
  task automatic t_rereset();
    do_reset();
    check("fault_hours", fault_hours, FH_MAX);
    nv = FH_MAX;
    nv_valid = 1'b1;
    @(negedge clk_i);
    nv_valid = 1'b0;
    repeat (2) @(negedge clk_i);
    check("fault_hours", fault_hours, FH_MAX);
    check("zone_enable", zone_en, 4'hF);
    $display("test second reset done");
  endtask : t_rereset

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up

  // main sequence
  initial begin
    t_boot();
    t_display();
    t_good();
    t_pause(PAUSE_0P1, BLOCK_PAUSE1_S);
    t_pause(PAUSE_0P2, BLOCK_PAUSE2_S);
    t_pause(8'h05, BLOCK_PAUSE3_S);
    t_no_progress();
    t_ext();
    t_rereset();
    wrap_up();
  end

  // watchdog: the run needs about 14000 cycles
  initial begin
    repeat (40000) @(posedge clk_i);
    n_errors++;
    wrap_up();
  end
endmodule : lube_fault_supervisor_tb

// [verification/lube_field_model.sv]
`timescale 1ns/100ps
// far side: piston detector and acknowledge key, each event a short high level
module lube_field_model (
  input  wire logic clk_i,
  input  wire logic det_req_i,
  input  wire logic key_req_i,
  output logic      detector_o,
  output logic      ack_key_o
);
  logic [2:0] det_cnt = 3'h0;
  logic [2:0] key_cnt = 3'h0;

  // six cycles high, long enough for the three-flop sampler to agree
  always_ff @(posedge clk_i) begin
    det_cnt <= det_req_i ? 3'h6 : (det_cnt != 3'h0 ? det_cnt - 3'h1 : 3'h0);
    key_cnt <= key_req_i ? 3'h6 : (key_cnt != 3'h0 ? key_cnt - 3'h1 : 3'h0);
  end

  // push-pull sensor and key: idle level is low
  assign detector_o = (det_cnt != 3'h0);
  assign ack_key_o  = (key_cnt != 3'h0);
endmodule : lube_field_model
